// ===== logic/media_mgmt_pkg.sv
// Purpose: Shared constants for the media, management, pin and wake register group.
// Assumes: Byte-wide register port with byte addresses as printed.
// Notes:   Offsets, field positions and most reset values live here; the bench and checker repeat offsets as literals.
package media_mgmt_pkg;

    localparam int ADDR_W = 9;
    localparam int DATA_W = 8;

    localparam logic [8:0] OFF_MEDIA_LINK_STATUS = 9'h137;
    localparam logic [8:0] OFF_MGMT_PHY_ADDRESS  = 9'h138;
    localparam logic [8:0] OFF_MGMT_DATA_LO      = 9'h139;
    localparam logic [8:0] OFF_MGMT_DATA_HI      = 9'h13a;
    localparam logic [8:0] OFF_MGMT_ACCESS_CTRL  = 9'h13b;
    localparam logic [8:0] OFF_GENERAL_PIN_CTRL  = 9'h13d;
    localparam logic [8:0] OFF_WAKE_EVENT_EN     = 9'h13e;

    // Media status fields.
    localparam int MS_TX_PAUSE   = 7;
    localparam int MS_RX_PAUSE   = 6;
    localparam int MS_DUPLEX     = 4;
    localparam int MS_SPEED      = 3;
    localparam int MS_LINK       = 2;
    localparam int MS_PAUSE_SENT = 1;
    localparam int MS_PAUSED     = 0;

    // Management access control fields.
    localparam int MA_OWNER   = 6;
    localparam int MA_DIR     = 5;
    localparam int MA_INDEX_W = 5;

    // General pin fields.
    localparam int GP_ALT_MEDIA = 4;
    localparam int GP_VAL1      = 3;
    localparam int GP_DIR1      = 2;
    localparam int GP_VAL0      = 1;
    localparam int GP_DIR0      = 0;

    // Wake enable fields.
    localparam int WE_LINK     = 6;
    localparam int WE_DIRECTED = 5;
    localparam int WE_PATTERNS = 5;

    localparam logic [4:0]  RST_PHY_ADDR  = 5'h00;
    localparam logic [15:0] RST_DATA_WORD = 16'h0000;
    localparam logic [4:0]  RST_REG_INDEX = 5'h00;
    localparam logic [1:0]  RST_GPIN      = 2'h0;
    localparam logic [6:0]  RST_WAKE_EN   = 7'h00;
    localparam logic [7:0]  RST_RDATA     = 8'h00;

    typedef enum logic [1:0] {
        MGMT_IDLE = 2'b01,
        MGMT_BUSY = 2'b10
    } mgmt_state_t;

endpackage : media_mgmt_pkg

// ===== logic/media_mgmt_gpio_wake_regs.sv
// Purpose: Media status, pause enables, management access, two general pins and wake enables.
// Assumes: Link, pause and wake inputs come from logic on clk_sys; general pins come from outside.
// Notes:   The management engine that shifts bits to the PHY sits outside and answers mgmt_done.
`timescale 1ns/100ps

module media_mgmt_gpio_wake_regs (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [8:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        eeprom_load,
    input  wire logic        eeprom_tx_pause,
    input  wire logic        eeprom_rx_pause,
    input  wire logic        autoneg_on,
    input  wire logic        partner_negotiated,
    input  wire logic        partner_pause_capable,
    input  wire logic        link_full_duplex,
    input  wire logic        link_speed_100,
    input  wire logic        link_up,
    input  wire logic        pause_sent_flag,
    input  wire logic        paused_by_remote_flag,
    input  wire logic        alt_media_capable,
    output logic             tx_pause_enable,
    output logic             rx_pause_enable,
    output logic             mgmt_req,
    output logic             mgmt_req_write,
    output logic      [4:0]  mgmt_target_addr,
    output logic      [4:0]  mgmt_reg_index,
    output logic      [15:0] mgmt_write_word,
    input  wire logic        mgmt_done,
    input  wire logic [15:0] mgmt_read_word,
    input  wire logic [1:0]  gpin_in,
    output logic      [1:0]  gpin_out,
    output logic      [1:0]  gpin_oe,
    input  wire logic        remote_wakeup_allowed,
    input  wire logic        link_change_event,
    input  wire logic        directed_packet_event,
    input  wire logic [4:0]  pattern_match_event,
    input  wire logic        wake_ack,
    output logic             remote_wake_request,
    output logic      [6:0]  wake_event_enables
);

    typedef struct packed {
        logic                       tx_pause_bit;
        logic                       rx_pause_bit;
        logic [4:0]                 phy_addr;
        logic [15:0]                data_word;
        logic                       direction;
        logic [4:0]                 reg_index;
        logic [1:0]                 gdir;
        logic [1:0]                 gval;
        logic [1:0]                 gsync1;
        logic [1:0]                 gsync2;
        logic [6:0]                 wake_en;
        logic                       wake_pending;
        media_mgmt_pkg::mgmt_state_t mstate;
        logic [7:0]                 rdata;
    } state_t;

    state_t cur;
    state_t next_cur;

    logic       tx_locked;
    logic       tx_invalid;
    logic       wr_hit;
    logic       busy;
    logic [1:0] gpin_level;
    logic [7:0] media_view;
    logic [7:0] pin_view;
    logic [7:0] access_view;
    logic       wake_trigger;

    always_comb begin
        // Partner negotiated with pause capability: the bit follows the result.
        tx_locked  = autoneg_on && partner_negotiated && partner_pause_capable;
        // Forced half duplex leaves the bit meaningless, so it reads zero.
        tx_invalid = !autoneg_on && !link_full_duplex;
        busy       = (cur.mstate == media_mgmt_pkg::MGMT_BUSY);
        wr_hit     = reg_wr;

        media_view = 8'h00;
        media_view[media_mgmt_pkg::MS_TX_PAUSE]   = cur.tx_pause_bit && !tx_invalid;
        media_view[media_mgmt_pkg::MS_RX_PAUSE]   = cur.rx_pause_bit;
        media_view[media_mgmt_pkg::MS_DUPLEX]     = link_full_duplex;
        media_view[media_mgmt_pkg::MS_SPEED]      = link_speed_100;
        media_view[media_mgmt_pkg::MS_LINK]       = link_up;
        media_view[media_mgmt_pkg::MS_PAUSE_SENT] = pause_sent_flag;
        media_view[media_mgmt_pkg::MS_PAUSED]     = paused_by_remote_flag;

        access_view = 8'h00;
        access_view[media_mgmt_pkg::MA_OWNER] = busy;
        access_view[media_mgmt_pkg::MA_DIR]   = cur.direction;
        access_view[4:0]                      = cur.reg_index;

        // An input pin shows its synchronised level, an output its driven value.
        for (int i = 0; i < 2; i++) begin
            gpin_level[i] = cur.gdir[i] ? cur.gval[i] : cur.gsync2[i];
        end
        pin_view = 8'h00;
        pin_view[media_mgmt_pkg::GP_ALT_MEDIA] = alt_media_capable;
        pin_view[media_mgmt_pkg::GP_VAL1]      = gpin_level[1];
        pin_view[media_mgmt_pkg::GP_DIR1]      = cur.gdir[1];
        pin_view[media_mgmt_pkg::GP_VAL0]      = gpin_level[0];
        pin_view[media_mgmt_pkg::GP_DIR0]      = cur.gdir[0];

        wake_trigger = (link_change_event && cur.wake_en[media_mgmt_pkg::WE_LINK])
                     || (directed_packet_event && cur.wake_en[media_mgmt_pkg::WE_DIRECTED])
                     || |(pattern_match_event & cur.wake_en[media_mgmt_pkg::WE_PATTERNS-1:0]);

        next_cur = cur;

        next_cur.gsync1 = gpin_in;
        next_cur.gsync2 = cur.gsync1;

        if (wr_hit) begin
            case (reg_addr)
                media_mgmt_pkg::OFF_MEDIA_LINK_STATUS: begin
                    if (!tx_locked && !tx_invalid) begin
                        next_cur.tx_pause_bit = reg_wdata[media_mgmt_pkg::MS_TX_PAUSE];
                    end
                    next_cur.rx_pause_bit = reg_wdata[media_mgmt_pkg::MS_RX_PAUSE];
                end
                media_mgmt_pkg::OFF_MGMT_PHY_ADDRESS: begin
                    next_cur.phy_addr = reg_wdata[4:0];
                end
                media_mgmt_pkg::OFF_MGMT_DATA_LO: begin
                    next_cur.data_word[7:0] = reg_wdata;
                end
                media_mgmt_pkg::OFF_MGMT_DATA_HI: begin
                    next_cur.data_word[15:8] = reg_wdata;
                end
                media_mgmt_pkg::OFF_MGMT_ACCESS_CTRL: begin
                    // Fields stay frozen while a transaction is in flight.
                    if (!busy) begin
                        next_cur.direction = reg_wdata[media_mgmt_pkg::MA_DIR];
                        next_cur.reg_index = reg_wdata[media_mgmt_pkg::MA_INDEX_W-1:0];
                        if (reg_wdata[media_mgmt_pkg::MA_OWNER]) begin
                            next_cur.mstate = media_mgmt_pkg::MGMT_BUSY;
                        end
                    end
                end
                media_mgmt_pkg::OFF_GENERAL_PIN_CTRL: begin
                    next_cur.gdir[1] = reg_wdata[media_mgmt_pkg::GP_DIR1];
                    next_cur.gdir[0] = reg_wdata[media_mgmt_pkg::GP_DIR0];
                    // The value bit of an input pin is read-only.
                    if (cur.gdir[1]) begin
                        next_cur.gval[1] = reg_wdata[media_mgmt_pkg::GP_VAL1];
                    end
                    if (cur.gdir[0]) begin
                        next_cur.gval[0] = reg_wdata[media_mgmt_pkg::GP_VAL0];
                    end
                end
                media_mgmt_pkg::OFF_WAKE_EVENT_EN: begin
                    next_cur.wake_en = reg_wdata[6:0];
                end
                default: begin
                end
            endcase
        end

        if (tx_locked) begin
            next_cur.tx_pause_bit = partner_pause_capable;
        end

        if (eeprom_load) begin
            next_cur.tx_pause_bit = eeprom_tx_pause;
            next_cur.rx_pause_bit = eeprom_rx_pause;
        end

        case (cur.mstate)
            media_mgmt_pkg::MGMT_IDLE: begin
            end
            media_mgmt_pkg::MGMT_BUSY: begin
                if (mgmt_done) begin
                    next_cur.mstate = media_mgmt_pkg::MGMT_IDLE;
                    if (!cur.direction) begin
                        next_cur.data_word = mgmt_read_word;
                    end
                end
            end
            default: begin
                next_cur.mstate = media_mgmt_pkg::MGMT_IDLE;
            end
        endcase

        // A new trigger in the acknowledge cycle keeps the request pending.
        if (wake_ack || !remote_wakeup_allowed) begin
            next_cur.wake_pending = 1'b0;
        end
        if (wake_trigger) begin
            next_cur.wake_pending = 1'b1;
        end

        next_cur.rdata = media_mgmt_pkg::RST_RDATA;
        if (reg_rd) begin
            case (reg_addr)
                media_mgmt_pkg::OFF_MEDIA_LINK_STATUS: next_cur.rdata = media_view;
                media_mgmt_pkg::OFF_MGMT_PHY_ADDRESS:  next_cur.rdata = {3'h0, cur.phy_addr};
                media_mgmt_pkg::OFF_MGMT_DATA_LO:      next_cur.rdata = cur.data_word[7:0];
                media_mgmt_pkg::OFF_MGMT_DATA_HI:      next_cur.rdata = cur.data_word[15:8];
                media_mgmt_pkg::OFF_MGMT_ACCESS_CTRL:  next_cur.rdata = access_view;
                media_mgmt_pkg::OFF_GENERAL_PIN_CTRL:  next_cur.rdata = pin_view;
                media_mgmt_pkg::OFF_WAKE_EVENT_EN:     next_cur.rdata = {1'b0, cur.wake_en};
                default:                               next_cur.rdata = media_mgmt_pkg::RST_RDATA;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cur.tx_pause_bit <= 1'b0;
            cur.rx_pause_bit <= 1'b0;
            cur.phy_addr     <= media_mgmt_pkg::RST_PHY_ADDR;
            cur.data_word    <= media_mgmt_pkg::RST_DATA_WORD;
            cur.direction    <= 1'b0;
            cur.reg_index    <= media_mgmt_pkg::RST_REG_INDEX;
            cur.gdir         <= media_mgmt_pkg::RST_GPIN;
            cur.gval         <= media_mgmt_pkg::RST_GPIN;
            cur.gsync1       <= media_mgmt_pkg::RST_GPIN;
            cur.gsync2       <= media_mgmt_pkg::RST_GPIN;
            cur.wake_en      <= media_mgmt_pkg::RST_WAKE_EN;
            cur.wake_pending <= 1'b0;
            cur.mstate       <= media_mgmt_pkg::MGMT_IDLE;
            cur.rdata        <= media_mgmt_pkg::RST_RDATA;
        end else begin
            cur <= next_cur;
        end
    end

    assign reg_rdata           = cur.rdata;
    // Pause only makes sense on a full-duplex link.
    assign tx_pause_enable     = cur.tx_pause_bit && link_full_duplex;
    assign rx_pause_enable     = cur.rx_pause_bit && link_full_duplex;
    assign mgmt_req            = (cur.mstate == media_mgmt_pkg::MGMT_BUSY);
    assign mgmt_req_write      = cur.direction;
    assign mgmt_target_addr    = cur.phy_addr;
    assign mgmt_reg_index      = cur.reg_index;
    assign mgmt_write_word     = cur.data_word;
    assign gpin_out            = cur.gval;
    assign gpin_oe             = cur.gdir;
    assign remote_wake_request = remote_wakeup_allowed && cur.wake_pending;
    assign wake_event_enables  = cur.wake_en;

endmodule : media_mgmt_gpio_wake_regs

// ===== bench/mgmt_phy_model.sv
// Purpose: Far side of the management handshake, standing in for the PHY register file.
// Assumes: One request at a time; phy_delay sets how long the answer takes.
// Notes:   Read data toggle outside the done cycle so that a stale word is never trusted.
`timescale 1ns/100ps
module mgmt_phy_model (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [3:0]  phy_delay,
    input  wire logic        mgmt_req,
    input  wire logic        mgmt_req_write,
    input  wire logic [4:0]  mgmt_reg_index,
    input  wire logic [15:0] mgmt_write_word,
    output logic             mgmt_done,
    output logic      [15:0] mgmt_read_word
);
    logic [15:0] phy_regs [32];
    logic [3:0]  wait_cnt;
    logic        busy;
    initial for (int i = 0; i < 32; i++) phy_regs[i] = 16'ha500 ^ 16'(i);
    always @(posedge clk_sys) begin
        mgmt_done <= 1'b0;
        mgmt_read_word <= ~mgmt_read_word;
        if (rst) begin
            busy <= 1'b0;
            mgmt_read_word <= 16'h0000;
        end else if (!busy) begin
            busy <= mgmt_req;
            wait_cnt <= phy_delay;
        end else if (wait_cnt != 4'h0) begin
            wait_cnt <= wait_cnt - 4'h1;
        end else if (mgmt_done) begin
            busy <= 1'b0;
        end else begin
            mgmt_done <= 1'b1;
            mgmt_read_word <= phy_regs[mgmt_reg_index];
            if (mgmt_req_write) phy_regs[mgmt_reg_index] <= mgmt_write_word;
        end
    end
endmodule : mgmt_phy_model

// ===== bench/media_mgmt_gpio_wake_regs_sva.sv
// Purpose: Port-level properties of the media, management, pin and wake register group.
// Assumes: One clock domain with synchronous active-high reset.
// Notes:   Bound to every instance of the register group.
`timescale 1ns/100ps
module media_mgmt_gpio_wake_regs_sva (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic [8:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       link_full_duplex,
    input wire logic       link_speed_100,
    input wire logic       link_up,
    input wire logic       pause_sent_flag,
    input wire logic       paused_by_remote_flag,
    input wire logic       tx_pause_enable,
    input wire logic       rx_pause_enable,
    input wire logic       mgmt_req,
    input wire logic       mgmt_done,
    input wire logic [1:0] gpin_oe,
    input wire logic       remote_wakeup_allowed,
    input wire logic       remote_wake_request
);
    wire [4:0] status_now = {link_full_duplex, link_speed_100, link_up, pause_sent_flag, paused_by_remote_flag};
    wire       start_wr = reg_wr && reg_addr == 9'h13b && reg_wdata[6];
    wire       pin_wr = reg_wr && reg_addr == 9'h13d;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    a_status_bits: assert property (reg_rd && reg_addr == 9'h137 |=>
        reg_rdata[4:0] == $past(status_now) && !reg_rdata[5]) else $error("media status bits wrong");
    a_addr_reserved: assert property (reg_rd && reg_addr == 9'h138 |=> reg_rdata[7:5] == 3'b000)
        else $error("phy address reserved bits not zero");
    a_tx_duplex_only: assert property (!link_full_duplex |-> !tx_pause_enable)
        else $error("tx pause enabled in half duplex");
    a_rx_duplex_only: assert property (!link_full_duplex |-> !rx_pause_enable)
        else $error("rx pause enabled in half duplex");
    a_req_hold: assert property (mgmt_req && !mgmt_done |=> mgmt_req) else $error("request dropped early");
    a_req_release: assert property (mgmt_req && mgmt_done |=> !mgmt_req) else $error("request kept after done");
    a_req_start: assert property ($rose(mgmt_req) |-> $past(start_wr)) else $error("request without owner write");
    a_pin_dir_write: assert property ($changed(gpin_oe) |-> $past(pin_wr)) else $error("pin enable moved alone");
    a_wake_gated: assert property (remote_wake_request |-> remote_wakeup_allowed)
        else $error("wake request without host permission");
endmodule : media_mgmt_gpio_wake_regs_sva
bind media_mgmt_gpio_wake_regs media_mgmt_gpio_wake_regs_sva chk_u (.clk_sys, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .link_full_duplex, .link_speed_100, .link_up, .pause_sent_flag,
    .paused_by_remote_flag, .tx_pause_enable, .rx_pause_enable, .mgmt_req, .mgmt_done, .gpin_oe,
    .remote_wakeup_allowed, .remote_wake_request);

// ===== bench/tb_media_mgmt_gpio_wake_regs.sv
// Purpose: Self-checking bench for the media, management, pin and wake registers.
// Assumes: mgmt_phy_model answers the management handshake.
// Notes:   Read answers are queued at issue and compared by a separate monitor.
`timescale 1ns/100ps
module tb_media_mgmt_gpio_wake_regs;
    logic clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_pend = 1'b0, eeprom_load = 1'b0;
    logic eeprom_tx_pause = 1'b1, eeprom_rx_pause = 1'b1, autoneg_on = 1'b0, partner_negotiated = 1'b0;
    logic partner_pause_capable = 1'b0, link_full_duplex = 1'b1, link_speed_100 = 1'b0, link_up = 1'b0;
    logic pause_sent_flag = 1'b0, paused_by_remote_flag = 1'b0, alt_media_capable = 1'b1, wake_ack = 1'b0;
    logic remote_wakeup_allowed = 1'b0, link_change_event = 1'b0, directed_packet_event = 1'b0;
    logic tx_pause_enable, rx_pause_enable, mgmt_req, mgmt_req_write, mgmt_done, remote_wake_request;
    logic [8:0] reg_addr = 9'h000;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, exp_q[$];
    logic [4:0] mgmt_target_addr, mgmt_reg_index, pattern_match_event = 5'h00;
    logic [15:0] mgmt_write_word, mgmt_read_word, w;
    logic [1:0] gpin_out, gpin_oe, pin_ext = 2'h0;
    logic [6:0] wake_event_enables;
    logic [3:0] phy_delay = 4'h0;
    int errors = 0, num_checks = 0, k;
    // A pin follows the design only while its enable is high; otherwise the outside level wins.
    wire [1:0] gpin_in = (gpin_oe & gpin_out) | (~gpin_oe & pin_ext);
    media_mgmt_gpio_wake_regs dut (.*);
    mgmt_phy_model phy (.*);
    initial forever #5 clk_sys = ~clk_sys;
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        num_checks++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    task automatic acc(input logic wr, input logic [8:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= wr;
        reg_rd <= !wr;
        if (!wr) exp_q.push_back(d);
        @(posedge clk_sys);
    endtask : acc
    task automatic idle(input int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge clk_sys);
    endtask : idle
    function automatic logic [7:0] ms(input logic [1:0] e);
        return {e, 1'b0, link_full_duplex, link_speed_100, link_up, pause_sent_flag, paused_by_remote_flag};
    endfunction : ms
    task automatic step(input logic [2:0] cfg, input logic [7:0] wd, input logic [1:0] e);
        {autoneg_on, partner_negotiated, partner_pause_capable} <= cfg;
        idle(1);
        acc(1'b1, 9'h137, wd);
        idle(1);
        acc(1'b0, 9'h137, ms(e));
        chk("tx_pause_enable", e[1], tx_pause_enable);
    endtask : step
    task automatic mgmt_run(input logic [7:0] ctl);
        acc(1'b1, 9'h13b, ctl);
        idle(2);
        chk("mgmt_req", 1'b1, mgmt_req);
        chk("mgmt_req_write", ctl[5], mgmt_req_write);
        chk("mgmt_reg_index", ctl[4:0], mgmt_reg_index);
        for (k = 0; k < 40 && mgmt_req !== 1'b0; k++) @(posedge clk_sys);
        if (k == 40) errors++;
        if (k == 40) report_and_stop();
        acc(1'b0, 9'h13b, ctl & 8'h3f);
    endtask : mgmt_run
    task automatic fire(input logic [6:0] ev, input logic e);
        {link_change_event, directed_packet_event, pattern_match_event} <= ev;
        @(posedge clk_sys);
        {link_change_event, directed_packet_event, pattern_match_event} <= 7'h00;
        @(posedge clk_sys);
        chk("remote_wake_request", e, remote_wake_request);
    endtask : fire
    always @(posedge clk_sys) begin
        if (rd_pend) chk("reg_rdata", exp_q.pop_front(), reg_rdata);
        rd_pend = reg_rd;
    end
    initial begin
        void'($urandom(32'h68ca6caa));
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        acc(1'b0, 9'h13e, 8'h00);
        acc(1'b0, 9'h13d, 8'h10);
        acc(1'b0, 9'h100, 8'h00);
        eeprom_load <= 1'b1;
        idle(1);
        eeprom_load <= 1'b0;
        for (k = 0; k < 6; k++) begin
            {link_speed_100, link_up, pause_sent_flag, paused_by_remote_flag} <= 4'($urandom);
            idle(1);
            acc(1'b0, 9'h137, ms(2'h3));
            chk("rx_pause_enable", 1'b1, rx_pause_enable);
        end
        link_full_duplex <= 1'b0;
        step(3'h0, 8'h00, 2'h0);
        link_full_duplex <= 1'b1;
        step(3'h6, 8'h40, 2'h1);
        step(3'h7, 8'h00, 2'h2);
        step(3'h4, 8'hc0, 2'h3);
        step(3'h0, 8'h40, 2'h1);
        acc(1'b1, 9'h138, 8'hff);
        acc(1'b0, 9'h138, 8'h1f);
        chk("mgmt_target_addr", 16'h001f, {11'h000, mgmt_target_addr});
        w = 16'($urandom);
        acc(1'b1, 9'h139, w[7:0]);
        acc(1'b1, 9'h13a, w[15:8]);
        phy_delay <= 4'($urandom);
        mgmt_run(8'heb);
        chk("mgmt_write_word", w, mgmt_write_word);
        mgmt_run(8'h4b);
        acc(1'b0, 9'h139, w[7:0]);
        acc(1'b0, 9'h13a, w[15:8]);
        phy_delay <= 4'h9;
        mgmt_run(8'h45);
        acc(1'b0, 9'h13a, 8'ha5);
        // The first write turns the pins to outputs; value bits only take once the pin is an output.
        acc(1'b1, 9'h13d, 8'h0f);
        acc(1'b1, 9'h13d, 8'h0f);
        idle(1);
        chk("gpin_oe", 2'h3, gpin_oe);
        chk("gpin_out", 2'h3, gpin_out);
        acc(1'b1, 9'h13d, 8'h0e);
        for (k = 0; k < 3; k++) begin
            pin_ext <= 2'($urandom);
            idle(3);
            acc(1'b0, 9'h13d, {6'h07, pin_ext[0], 1'b0});
        end
        acc(1'b1, 9'h13e, 8'hff);
        acc(1'b0, 9'h13e, 8'h7f);
        chk("wake_event_enables", 16'h007f, {9'h000, wake_event_enables});
        remote_wakeup_allowed <= 1'b1;
        for (k = 0; k < 7; k++) begin
            acc(1'b1, 9'h13e, 8'h01 << k);
            idle(1);
            fire(~(7'h01 << k), 1'b0);
            fire(7'h01 << k, 1'b1);
            wake_ack <= 1'b1;
            fire(7'h00, 1'b0);
            wake_ack <= 1'b0;
        end
        remote_wakeup_allowed <= 1'b0;
        fire(7'h7f, 1'b0);
        report_and_stop();
    end
endmodule : tb_media_mgmt_gpio_wake_regs
